/* File: dtp_pkg.sv */
package dtp_pkg;
  // ==========================================
  // Sizes
  localparam int CNT_W  = 10;
  localparam int PSC_W  = 8;
  localparam int ADDR_W = 8;
  // ==========================================
  // Register indices, byte address is four times
  localparam logic [ADDR_W-1:0] IDX_COUNT_LOW = 8'h10;
  localparam logic [ADDR_W-1:0] IDX_CTRL_ONE  = 8'h11;
  localparam logic [ADDR_W-1:0] IDX_CTRL_TWO  = 8'h12;
  localparam logic [ADDR_W-1:0] IDX_DUTY_LOW  = 8'h13;
  localparam logic [ADDR_W-1:0] IDX_HIGH_BITS = 8'h16;
  // ==========================================
  // Control one fields
  localparam int B_TIMER_EN  = 0;
  localparam int B_RELOAD    = 1;
  localparam int B_ONE_SHOT  = 2;
  localparam int B_POLARITY  = 6;
  localparam int B_OUT_EN    = 7;
  localparam logic [7:0] CTRL_ONE_MASK = 8'hc7;
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  // ==========================================
  // Control two fields
  localparam int B_SEL_LO    = 0;
  localparam int B_PSC_DIS   = 3;
  localparam int B_EDGE_FALL = 4;
  localparam int B_CLK_EXT   = 5;
  localparam logic [7:0] CTRL_TWO_MASK = 8'h3f;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h3f;
  // ==========================================
  // High bits register fields
  localparam int B_DUTY_HI   = 0;
  localparam int B_RELOAD_HI = 4;
  localparam logic [7:0] HIGH_MASK = 8'h33;
  localparam logic [7:0] HIGH_RST  = 8'h00;
  // ==========================================
  // Counter and bus constants
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 10'h000;
  localparam logic [PSC_W-1:0] PSC_RST      = 8'hff;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: dtp_down_timer_pwm.sv */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dtp_down_timer_pwm #(
  parameter int CNT_W = dtp_pkg::CNT_W,
  parameter int PSC_W = dtp_pkg::PSC_W
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  // Count sources
  input  wire logic             instrClkTick,
  input  wire logic             externalClockPin,
  // Shared pin, GPIO side and pad side
  input  wire logic             gpioOut,
  input  wire logic             gpioOe,
  output logic                  pwmSharedPinOut,
  output logic                  pwmSharedPinOe,
  // AXI4-Lite write address and data
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // ==========================================
  // Helpers
  function automatic logic mapped(input logic [31:0] a);
    logic [dtp_pkg::ADDR_W-1:0] i;
    i = a[dtp_pkg::ADDR_W+1:2];
    mapped = (a[1:0] == 2'h0) && (a[31:dtp_pkg::ADDR_W+2] == '0) &&
             (i == dtp_pkg::IDX_COUNT_LOW || i == dtp_pkg::IDX_CTRL_ONE ||
              i == dtp_pkg::IDX_CTRL_TWO || i == dtp_pkg::IDX_DUTY_LOW ||
              i == dtp_pkg::IDX_HIGH_BITS);
  endfunction

  function automatic logic [dtp_pkg::ADDR_W-1:0] regIdx(input logic [31:0] a);
    regIdx = a[dtp_pkg::ADDR_W+1:2];
  endfunction

  // ==========================================
  // Registers and state
  logic [7:0]       ctrlOne;
  logic [7:0]       ctrlTwo;
  logic [7:0]       highBits;
  logic [7:0]       reloadLow;
  logic [7:0]       dutyLow;
  logic [CNT_W-1:0] downCounter;
  logic [PSC_W-1:0] prescCnt;
  logic             extSync1;
  logic             extSync2;
  logic             extPrev;
  logic             pwmRaw;

  logic [31:0] awAddr;
  logic        awFull;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wFull;

  // Control fields
  logic             timerEn;
  logic             reloadSel;
  logic             oneShot;
  logic             polarity;
  logic             outEn;
  logic [2:0]       divSel;
  logic             prescDis;
  logic             edgeFall;
  logic             clkExt;
  logic [CNT_W-1:0] reloadVal;
  logic [CNT_W-1:0] dutyVal;

  assign timerEn   = ctrlOne[dtp_pkg::B_TIMER_EN];
  assign reloadSel = ctrlOne[dtp_pkg::B_RELOAD];
  assign oneShot   = ctrlOne[dtp_pkg::B_ONE_SHOT];
  assign polarity  = ctrlOne[dtp_pkg::B_POLARITY];
  assign outEn     = ctrlOne[dtp_pkg::B_OUT_EN];
  assign divSel    = ctrlTwo[dtp_pkg::B_SEL_LO +: 3];
  assign prescDis  = ctrlTwo[dtp_pkg::B_PSC_DIS];
  assign edgeFall  = ctrlTwo[dtp_pkg::B_EDGE_FALL];
  assign clkExt    = ctrlTwo[dtp_pkg::B_CLK_EXT];
  assign reloadVal = {highBits[dtp_pkg::B_RELOAD_HI +: 2], reloadLow};
  assign dutyVal   = {highBits[dtp_pkg::B_DUTY_HI +: 2], dutyLow};

  // ==========================================
  // Bus write path
  logic doWrite;
  logic wrHit;
  logic [dtp_pkg::ADDR_W-1:0] wrIdx;
  logic [7:0] wrByte;

  assign doWrite = awFull && wFull && !s_axi_bvalid;
  assign wrHit   = doWrite && mapped(awAddr) && wStrb[0];
  assign wrIdx   = regIdx(awAddr);
  assign wrByte  = wData[7:0];

  // Address and data may arrive in either order
  always_ff @(posedge clk) begin
    if (reset) begin
      awFull        <= 1'b0;
      awAddr        <= '0;
      s_axi_awready <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awFull <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awFull <= 1'b0;
      end
      s_axi_awready <= !awFull && !s_axi_awready && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wFull        <= 1'b0;
      wData        <= '0;
      wStrb        <= '0;
      s_axi_wready <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wFull <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wFull <= 1'b0;
      end
      s_axi_wready <= !wFull && !s_axi_wready && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dtp_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlOne  <= dtp_pkg::CTRL_ONE_RST;
      ctrlTwo  <= dtp_pkg::CTRL_TWO_RST;
      highBits <= dtp_pkg::HIGH_RST;
      dutyLow  <= '0;
    end else if (clkEn && wrHit) begin
      case (wrIdx)
        dtp_pkg::IDX_CTRL_ONE:  ctrlOne  <= wrByte & dtp_pkg::CTRL_ONE_MASK;
        dtp_pkg::IDX_CTRL_TWO:  ctrlTwo  <= wrByte & dtp_pkg::CTRL_TWO_MASK;
        dtp_pkg::IDX_HIGH_BITS: highBits <= wrByte & dtp_pkg::HIGH_MASK;
        dtp_pkg::IDX_DUTY_LOW:  dutyLow  <= wrByte;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Bus read path
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= dtp_pkg::RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
        case (regIdx(s_axi_araddr))
          dtp_pkg::IDX_COUNT_LOW: s_axi_rdata <= {24'h0, downCounter[7:0]};
          dtp_pkg::IDX_CTRL_ONE:  s_axi_rdata <= {24'h0, ctrlOne};
          dtp_pkg::IDX_CTRL_TWO:  s_axi_rdata <= {24'h0, ctrlTwo};
          dtp_pkg::IDX_HIGH_BITS: s_axi_rdata <= {24'h0, highBits};
          // Duty byte is write only
          default:                s_axi_rdata <= '0;
        endcase
        if (!mapped(s_axi_araddr)) begin
          s_axi_rdata <= '0;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Pin clock sampling
  always_ff @(posedge clk) begin
    if (reset) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev  <= 1'b0;
    end else if (clkEn) begin
      extSync1 <= externalClockPin;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
    end
  end

  // ==========================================
  // Count event selection
  logic extRise;
  logic extFall;
  logic srcEvent;
  logic prescHit;
  logic countTick;
  logic [PSC_W-1:0] divMask;

  assign extRise = extSync2 && !extPrev;
  assign extFall = !extSync2 && extPrev;
  assign srcEvent = clkExt ? (edgeFall ? extFall : extRise) : instrClkTick;
  assign divMask  = PSC_W'((9'h2 << divSel) - 9'h1);
  assign prescHit = (prescCnt & divMask) == divMask;
  assign countTick = srcEvent && (prescDis || prescHit);

  // Prescaler idles while disabled
  always_ff @(posedge clk) begin
    if (reset) begin
      prescCnt <= dtp_pkg::PSC_RST;
    end else if (clkEn && srcEvent && !prescDis) begin
      prescCnt <= prescCnt + 1'b1;
    end
  end

  // ==========================================
  // Down counter
  logic cntWrite;
  assign cntWrite = wrHit && wrIdx == dtp_pkg::IDX_COUNT_LOW;

  always_ff @(posedge clk) begin
    if (reset) begin
      reloadLow <= '0;
    end else if (clkEn && cntWrite) begin
      reloadLow <= wrByte;
    end
  end

  // Software load beats a tick in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      downCounter <= dtp_pkg::CNT_ZERO;
    end else if (clkEn) begin
      if (cntWrite) begin
        downCounter <= {highBits[dtp_pkg::B_RELOAD_HI +: 2], wrByte};
      end else if (timerEn && countTick) begin
        if (downCounter != dtp_pkg::CNT_ZERO) begin
          downCounter <= downCounter - 1'b1;
        end else if (oneShot) begin
          downCounter <= dtp_pkg::CNT_ZERO;
        end else if (reloadSel) begin
          downCounter <= reloadVal;
        end else begin
          downCounter <= dtp_pkg::CNT_ALL_ONES;
        end
      end
    end
  end

  // ==========================================
  // Waveform and pin
  always_ff @(posedge clk) begin
    if (reset) begin
      pwmRaw <= 1'b0;
    end else if (clkEn) begin
      pwmRaw <= (downCounter <= dutyVal) ^ polarity;
    end
  end

  // Pad mux registered so pin never glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      pwmSharedPinOut <= 1'b0;
      pwmSharedPinOe  <= 1'b0;
    end else if (clkEn) begin
      pwmSharedPinOut <= outEn ? pwmRaw : gpioOut;
      pwmSharedPinOe  <= outEn ? 1'b1 : gpioOe;
    end
  end

  // ==========================================
  // Checks
  sequence sq_cnt_write;
    clkEn && cntWrite;
  endsequence
  sequence sq_tick_free;
    clkEn && !cntWrite && timerEn && countTick;
  endsequence

  AST_COUNT_LOAD: assert property (@(posedge clk) disable iff (reset)
    sq_cnt_write |=> downCounter == {$past(highBits[dtp_pkg::B_RELOAD_HI +: 2]), $past(wrByte)})
    else $error("count write did not load counter");
  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    (clkEn && !cntWrite && !timerEn) |=> $stable(downCounter))
    else $error("counter moved while disabled");
  AST_WRAP: assert property (@(posedge clk) disable iff (reset)
    (sq_tick_free ##0 (downCounter == dtp_pkg::CNT_ZERO && !oneShot && !reloadSel))
    |=> downCounter == dtp_pkg::CNT_ALL_ONES)
    else $error("no wrap to all ones");
  AST_RELOAD: assert property (@(posedge clk) disable iff (reset)
    (sq_tick_free ##0 (downCounter == dtp_pkg::CNT_ZERO && !oneShot && reloadSel))
    |=> downCounter == $past(reloadVal))
    else $error("no reload on underflow");
  AST_ONE_SHOT: assert property (@(posedge clk) disable iff (reset)
    (clkEn && !cntWrite && oneShot && downCounter == dtp_pkg::CNT_ZERO)
    |=> downCounter == dtp_pkg::CNT_ZERO)
    else $error("one shot left zero");
  AST_READ: assert property (@(posedge clk) disable iff (reset)
    (clkEn && s_axi_arvalid && s_axi_arready &&
     s_axi_araddr == {22'h0, dtp_pkg::IDX_COUNT_LOW, 2'h0})
    |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(downCounter[7:0])})
    else $error("count read mismatch");
  AST_PWM_LEVEL: assert property (@(posedge clk) disable iff (reset)
    clkEn |=> pwmRaw == (($past(downCounter) <= $past(dutyVal)) ^ $past(polarity)))
    else $error("waveform level wrong");
  AST_PIN: assert property (@(posedge clk) disable iff (reset)
    (clkEn && outEn) |=> pwmSharedPinOe && pwmSharedPinOut == $past(pwmRaw))
    else $error("pin not driven by waveform");
  AST_EDGE: assert property (@(posedge clk) disable iff (reset)
    (sq_tick_free ##0 (clkExt && !edgeFall)) |-> $rose(extSync2))
    else $error("tick without rising edge");
  AST_DIRECT: assert property (@(posedge clk) disable iff (reset)
    (clkEn && !cntWrite && timerEn && prescDis && srcEvent && downCounter != dtp_pkg::CNT_ZERO)
    |=> downCounter == $past(downCounter) - CNT_W'(1))
    else $error("direct event did not decrement");
  AST_DIV2: assert property (@(posedge clk) disable iff (reset)
    (clkEn && !prescDis && divSel == 3'h0 && countTick) ##1 (clkEn && srcEvent &&
     $stable(ctrlTwo)) |-> !countTick)
    else $error("divide by two ticked twice");
endmodule

/* File: dtp_pin_partner.sv */
`timescale 1ns/10ps
module dtp_pin_partner (
  // Bench request for the pin clock
  input  wire logic extReq,
  // Pad side of the shared pin
  input  wire logic pinOut,
  input  wire logic pinOe,
  output logic      externalClockPin,
  output logic      padLevel
);
  // ==========================================
  // Pin clock
  initial externalClockPin = 1'b0;
  // pin clock edges
  // Skewed off the system clock so the synchroniser sees an async edge
  always @(extReq) externalClockPin <= #1.3 extReq;
  // ==========================================
  // Pad
  // pull-up when undriven
  assign padLevel = pinOe ? pinOut : 1'b1;
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
  // ==========================================
  // Signals
  logic        clk, reset, clkEn, instrClkTick, externalClockPin, gpioOut, gpioOe;
  logic        pwmSharedPinOut, pwmSharedPinOe, padLevel, extReq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          errors = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  localparam logic [31:0] A_CNT  = {22'h0, dtp_pkg::IDX_COUNT_LOW, 2'h0};
  localparam logic [31:0] A_C1   = {22'h0, dtp_pkg::IDX_CTRL_ONE, 2'h0};
  localparam logic [31:0] A_C2   = {22'h0, dtp_pkg::IDX_CTRL_TWO, 2'h0};
  localparam logic [31:0] A_DUTY = {22'h0, dtp_pkg::IDX_DUTY_LOW, 2'h0};
  localparam logic [31:0] A_HI   = {22'h0, dtp_pkg::IDX_HIGH_BITS, 2'h0};
  localparam logic [1:0]  OK     = dtp_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR    = dtp_pkg::RESP_SLVERR;

  dtp_down_timer_pwm dut (.*);
  dtp_pin_partner partner (
    .extReq           (extReq),
    .pinOut           (pwmSharedPinOut),
    .pinOe            (pwmSharedPinOe),
    .externalClockPin (externalClockPin),
    .padLevel         (padLevel)
  );

  // ==========================================
  // Common tasks
  task automatic finish_test();
    $display("Checks: %0d mismatches: %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bready stays high, so only the channel readys decide the pace
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = OK);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rdreg(input logic [31:0] a, input logic [7:0] exp, input logic [1:0] er = OK);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h0, exp});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      instrClkTick <= 1'b1;
      @(posedge clk);
      instrClkTick <= 1'b0;
    end
    repeat (5) @(posedge clk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rdreg(A_C2, 8'h3f);
    rdreg(A_C1, 8'h00);
    rdreg(A_DUTY, 8'h00);
    rdreg(32'h7c, 8'h00, ERR);
    wr(A_C1, 8'h01, 4'h0);
    rdreg(A_C1, 8'h00);
    wr(32'h41, 8'h01, 4'hf, ERR);
    $display("reset test done");
  endtask
  task automatic t_load();
    wr(A_C2, 8'h08);
    wr(A_HI, 8'h10);
    wr(A_CNT, 8'h05);
    rdreg(A_CNT, 8'h05);
    tick(3);
    rdreg(A_CNT, 8'h05);
    wr(A_C1, 8'h03);
    tick(6);
    rdreg(A_CNT, 8'hff);
    // Enable low freezes the counter though ticks keep coming
    clkEn <= 1'b0;
    tick(3);
    clkEn <= 1'b1;
    rdreg(A_CNT, 8'hff);
    $display("load test done");
  endtask
  task automatic t_modes();
    logic [7:0] mode [4] = '{8'h01, 8'h03, 8'h05, 8'h07};
    logic [7:0] expv [4] = '{8'hfe, 8'h02, 8'h00, 8'h00};
    wr(A_HI, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(A_C1, mode[i]);
      wr(A_CNT, 8'h03);
      tick(5);
      rdreg(A_CNT, expv[i]);
    end
    $display("mode test done");
  endtask
  task automatic t_psc();
    wr(A_C2, 8'h09);
    wr(A_C2, 8'h01);
    wr(A_C1, 8'h01);
    wr(A_CNT, 8'h10);
    // Eight events make two hits at 1:4 whatever the divider phase
    tick(8);
    rdreg(A_CNT, 8'h0e);
    // Select changes only with the prescaler off
    wr(A_C2, 8'h09);
    wr(A_C2, 8'h08);
    wr(A_C2, 8'h00);
    wr(A_CNT, 8'h10);
    // Back-to-back events, so 1:2 must skip every other one
    instrClkTick <= 1'b1;
    repeat (4) @(posedge clk);
    instrClkTick <= 1'b0;
    tick(0);
    rdreg(A_CNT, 8'h0e);
    wr(A_C2, 8'h08);
    $display("prescaler test done");
  endtask
  task automatic t_ext(input bit fall);
    wr(A_C2, fall ? 8'h38 : 8'h28);
    wr(A_CNT, 8'h10);
    extReq <= 1'b1;
    tick(1);
    rdreg(A_CNT, fall ? 8'h10 : 8'h0f);
    extReq <= 1'b0;
    tick(1);
    rdreg(A_CNT, 8'h0f);
    $display("pin clock test done");
  endtask
  task automatic t_pwm();
    wr(A_C2, 8'h08);
    wr(A_DUTY, 8'h02);
    wr(A_CNT, 8'h05);
    wr(A_C1, 8'h83);
    tick(0);
    chk({31'h0, pwmSharedPinOe}, 32'h1);
    chk({31'h0, padLevel}, 32'h0);
    tick(3);
    chk({31'h0, padLevel}, 32'h1);
    wr(A_C1, 8'hc3);
    tick(0);
    chk({31'h0, padLevel}, 32'h0);
    wr(A_C1, 8'h83);
    wr(A_HI, 8'h01);
    wr(A_CNT, 8'h05);
    tick(0);
    chk({31'h0, padLevel}, 32'h1);
    wr(A_C1, 8'h03);
    gpioOe <= 1'b1;
    gpioOut <= 1'b1;
    tick(0);
    chk({30'h0, pwmSharedPinOe, padLevel}, 32'h3);
    gpioOut <= 1'b0;
    tick(0);
    chk({31'h0, padLevel}, 32'h0);
    gpioOe <= 1'b0;
    tick(0);
    chk({31'h0, pwmSharedPinOe}, 32'h0);
    $display("waveform test done");
  endtask

  // ==========================================
  // Clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    reset = 1'b1;
    clkEn = 1'b1;
    instrClkTick = 1'b0;
    gpioOut = 1'b0;
    gpioOe = 1'b0;
    extReq = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_load();
    t_modes();
    t_psc();
    t_ext(1'b0);
    t_ext(1'b1);
    t_pwm();
    finish_test();
  end
endmodule
